// ---- hpc_defines.svh ----
`ifndef HPC_DEFINES_SVH
`define HPC_DEFINES_SVH
// Core-side address of the port control register
`define HPC_CTRL_ADDR 24'hFFFFC4
`define HPC_CTRL_RST  16'h0000
// Bit 7 is reserved and never stored
`define HPC_CTRL_WMASK 16'hFF7F
// Shared pin positions
`define HPC_P_A8  0
`define HPC_P_A9  1
`define HPC_P_CS  2
`define HPC_P_REQ 3
`define HPC_P_ACK 4
`define HPC_NPIN  5
`endif

// ---- hpc_host_model.sv ----
module hpc_host_model
    import hpc_pkg::*;
(
    // Configuration known to the host
    input  wire hpc_ctrl_t   cfg,
    // Commanded bus activity
    input  wire logic        cyc_rd,
    input  wire logic        cyc_wr,
    input  wire logic        ack_on,
    input  wire logic [2:0]  addr,
    // Device pin drive
    input  wire logic [4:0]  pin_o,
    input  wire logic [4:0]  pin_oe,
    // Host bus levels
    output logic      [4:0]  pin_i,
    output logic             host_as_in,
    output logic             data_strobe_in,
    output logic             read_strobe_in,
    output logic             write_strobe_in,
    output logic             host_rw_in,
    output logic      [2:0]  host_ad_in,
    output logic      [2:0]  host_addr_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sel_on;

    assign sel_on          = cyc_rd | cyc_wr;
    assign host_as_in      = sel_on ~^ cfg.addr_strobe_polarity;
    assign data_strobe_in  = (sel_on & ~cfg.dual_strobe_select) ~^ cfg.strobe_polarity;
    assign read_strobe_in  = (cyc_rd & cfg.dual_strobe_select) ~^ cfg.strobe_polarity;
    assign write_strobe_in = (cyc_wr & cfg.dual_strobe_select) ~^ cfg.strobe_polarity;
    assign host_rw_in      = cyc_rd;
    // Released multiplexed bus shows the inverse, never the old address
    assign host_ad_in      = sel_on ? addr : ~addr;
    assign host_addr_in    = addr;
    // Pull-ups on released address and request pins; host drives released select and acknowledge
    assign pin_i[1:0]      = pin_o[1:0] | ~pin_oe[1:0];
    assign pin_i[2]        = pin_oe[2] ? pin_o[2] : (sel_on ~^ cfg.select_polarity);
    assign pin_i[3]        = pin_o[3] | ~pin_oe[3];
    assign pin_i[4]        = pin_oe[4] ? pin_o[4] : (ack_on ~^ cfg.ack_polarity);
endmodule : hpc_host_model

// ---- hpc_pkg.sv ----
package hpc_pkg;
    typedef struct packed {
        logic ack_polarity;
        logic request_polarity;
        logic select_polarity;
        logic dual_strobe_select;
        logic muxed_bus_select;
        logic addr_strobe_polarity;
        logic strobe_polarity;
        logic request_open_drain;
        logic reserved7;
        logic interface_enable;
        logic ack_pin_enable;
        logic request_pin_enable;
        logic select_pin_enable;
        logic addr9_pin_enable;
        logic addr8_pin_enable;
        logic gpio_port_enable;
    } hpc_ctrl_t;

    // Host-side strobes and address, sampled through two flops
    typedef struct packed {
        logic [4:0] pin;
        logic       as;
        logic       ds;
        logic       rd;
        logic       wr;
        logic       rw;
        logic [2:0] ad;
        logic [2:0] addr;
    } hpc_hin_t;

    typedef struct packed {
        hpc_ctrl_t  ctrl;
        hpc_hin_t   s1;
        hpc_hin_t   s2;
        logic [2:0] alatch;
        logic [15:0] rdata;
        logic [4:0] pin_fn;
        logic [4:0] pin_o;
        logic [4:0] pin_oe;
        logic [4:0] gpio_in;
        logic [2:0] reg_addr;
        logic       host_sel;
        logic       xfer_rd;
        logic       xfer_wr;
        logic [7:0] vec_o;
        logic       vec_oe;
        logic       ifc_reset;
    } hpc_st_t;
endpackage : hpc_pkg

// ---- hpc_port_ctrl.sv ----
// Contract
// - Port control register is 16 bits, core read/write, selects configuration.
// - Bit 0 enables GPIO pins; clear makes them high-Z and inputs disconnected.
// - Bit 1 makes shared pin address line 8 in multiplexed mode only.
// - Bit 2 makes shared pin address line 9 in multiplexed mode only.
// - Bit 3 makes pin chip select (non-mux) or address line 10 (mux).
// - Bit 4 enables request pin, or transmit and receive request pins.
// - Acknowledge input needs bits 5 and 4 in single-request mode.
// - Bit 6 enables interface; clear turns all pins into GPIO.
// - Reserved bit 7 reads as zero.
// - Bit 8 makes enabled request outputs open drain, else always driven.
// - Bit 9 sets data strobe polarity, low or high active.
// - Bit 10 sets address strobe polarity; address sampled while strobe active.
// - Bit 11 latches multiplexed low address, else address taken from pins.
// - Bit 12 selects single strobe or separate read and write strobes.
// - Bit 13 sets chip select polarity, ignored in multiplexed mode.
// - Bit 14 sets request output polarity, low or high active.
// - Bit 15 sets acknowledge polarity; vector driven while acknowledge active.
// - Hardware and software reset clear the whole register.
// - Clearing interface enable applies an individual reset to the interface.
`include "hpc_defines.svh"

module hpc_port_ctrl
    import hpc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        sw_reset,
    // Core register port
    input  wire logic [23:0] core_addr,
    input  wire logic        core_wr,
    input  wire logic        core_rd,
    input  wire logic [15:0] core_wdata,
    output logic      [15:0] core_rdata,
    // Internal interface state
    input  wire logic        dual_request_mode,
    input  wire logic        tx_req,
    input  wire logic        rx_req,
    input  wire logic [7:0]  vector_reg,
    input  wire logic [4:0]  pin_direction_reg,
    input  wire logic [4:0]  pin_value_reg,
    // Host pins
    input  wire logic [4:0]  pin_i,
    input  wire logic        host_as_in,
    input  wire logic        data_strobe_in,
    input  wire logic        read_strobe_in,
    input  wire logic        write_strobe_in,
    input  wire logic        host_rw_in,
    input  wire logic [2:0]  host_ad_in,
    input  wire logic [2:0]  host_addr_in,
    output logic      [4:0]  pin_o,
    output logic      [4:0]  pin_oe,
    output logic      [7:0]  vec_o,
    output logic             vec_oe,
    // Decoded interface view
    output logic      [4:0]  pin_fn,
    output logic      [4:0]  gpio_in,
    output logic      [2:0]  reg_addr,
    output logic             host_sel,
    output logic             xfer_rd,
    output logic             xfer_wr,
    output logic             ifc_reset
);

    hpc_st_t   st;
    hpc_st_t   next_st;
    hpc_ctrl_t c;
    hpc_hin_t  h;
    logic [4:0] fn;
    logic [4:0] g_o;
    logic [4:0] g_oe;
    logic [4:0] g_in;
    logic       hit;

    assign c   = st.ctrl;
    assign h   = st.s2;
    assign hit = (core_addr == `HPC_CTRL_ADDR);

    // Pin function decode
    assign fn[`HPC_P_A8] = c.interface_enable & c.muxed_bus_select
                         & c.addr8_pin_enable;
    assign fn[`HPC_P_A9] = c.interface_enable & c.muxed_bus_select
                         & c.addr9_pin_enable;
    assign fn[`HPC_P_CS] = c.interface_enable
                         & c.select_pin_enable;
    assign fn[`HPC_P_REQ] = c.interface_enable
                          & c.request_pin_enable;
    assign fn[`HPC_P_ACK] = c.interface_enable & c.request_pin_enable
                          & (dual_request_mode | c.ack_pin_enable);

    // GPIO path per pin, disconnected unless port enabled
    genvar gi;
    generate
        for (gi = 0; gi < `HPC_NPIN; gi++) begin : g_pin
            assign g_o[gi]  = pin_value_reg[gi];
            assign g_oe[gi] = ~fn[gi] & c.gpio_port_enable
                            & pin_direction_reg[gi];
            assign g_in[gi] = ~fn[gi] & c.gpio_port_enable
                            & h.pin[gi];
        end
    endgenerate

    always_comb begin
        logic lvl_tx;
        logic lvl_rx;
        logic cs_act;
        logic as_act;
        logic ds_act;
        logic rd_act;
        logic wr_act;
        logic ack_act;
        logic sel;
        next_st = st;
        sel     = 1'b0;
        lvl_tx  = ~(tx_req ^ c.request_polarity);
        lvl_rx  = ~(rx_req ^ c.request_polarity);
        cs_act  = (h.pin[`HPC_P_CS] == c.select_polarity);
        as_act  = (h.as == c.addr_strobe_polarity);
        ds_act  = (h.ds == c.strobe_polarity);
        rd_act  = (h.rd == c.strobe_polarity);
        wr_act  = (h.wr == c.strobe_polarity);
        ack_act = fn[`HPC_P_ACK] & ~dual_request_mode
                & (h.pin[`HPC_P_ACK] == c.ack_polarity);

        next_st.s1 = '{pin: pin_i, as: host_as_in, ds: data_strobe_in,
                       rd: read_strobe_in, wr: write_strobe_in,
                       rw: host_rw_in, ad: host_ad_in, addr: host_addr_in};
        next_st.s2 = st.s1;

        // Register write; reserved bit never stored
        if (sw_reset) begin
            next_st.ctrl = hpc_ctrl_t'(`HPC_CTRL_RST);
        end else if (core_wr && hit) begin
            next_st.ctrl = hpc_ctrl_t'(core_wdata & `HPC_CTRL_WMASK);
        end
        if (core_rd && hit) begin
            next_st.rdata = st.ctrl & `HPC_CTRL_WMASK;
        end else begin
            next_st.rdata = 16'h0000;
        end

        next_st.pin_fn  = fn;
        next_st.pin_o   = g_o;
        next_st.pin_oe  = g_oe;
        next_st.gpio_in = g_in;

        // Request outputs
        if (fn[`HPC_P_REQ]) begin
            next_st.pin_o[`HPC_P_REQ]  = c.request_open_drain ? 1'b0 : lvl_tx;
            next_st.pin_oe[`HPC_P_REQ] = c.request_open_drain ? ~lvl_tx : 1'b1;
        end
        if (fn[`HPC_P_ACK]) begin
            if (dual_request_mode) begin
                next_st.pin_o[`HPC_P_ACK]  = c.request_open_drain ? 1'b0 : lvl_rx;
                next_st.pin_oe[`HPC_P_ACK] = c.request_open_drain ? ~lvl_rx : 1'b1;
            end else begin
                next_st.pin_o[`HPC_P_ACK]  = 1'b0;
                next_st.pin_oe[`HPC_P_ACK] = 1'b0;
            end
        end

        // Vector onto host bus during acknowledge
        next_st.vec_o  = vector_reg;
        next_st.vec_oe = ack_act;

        // Address path
        if (c.muxed_bus_select && as_act) begin
            next_st.alatch = h.ad;
        end
        next_st.reg_addr = c.muxed_bus_select ? st.alatch : h.addr;

        // Select and transfer strobes
        sel = c.interface_enable
            & (c.muxed_bus_select | (fn[`HPC_P_CS] & cs_act));
        next_st.host_sel = sel;
        if (c.dual_strobe_select) begin
            next_st.xfer_rd = sel & rd_act;
            next_st.xfer_wr = sel & wr_act;
        end else begin
            next_st.xfer_rd = sel & ds_act & h.rw;
            next_st.xfer_wr = sel & ds_act & ~h.rw;
        end
        next_st.ifc_reset = ~c.interface_enable;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign core_rdata = st.rdata;
    assign pin_o      = st.pin_o;
    assign pin_oe     = st.pin_oe;
    assign vec_o      = st.vec_o;
    assign vec_oe     = st.vec_oe;
    assign pin_fn     = st.pin_fn;
    assign gpio_in    = st.gpio_in;
    assign reg_addr   = st.reg_addr;
    assign host_sel   = st.host_sel;
    assign xfer_rd    = st.xfer_rd;
    assign xfer_wr    = st.xfer_wr;
    assign ifc_reset  = st.ifc_reset;

    a_write_store: assert property (@(posedge sys_clk) disable iff (rst)
        core_wr && hit && !sw_reset |=>
            st.ctrl == ($past(core_wdata) & `HPC_CTRL_WMASK))
        else $error("control write not stored");

    a_read_back: assert property (@(posedge sys_clk) disable iff (rst)
        core_rd && hit |=> core_rdata == ($past(st.ctrl) & 16'hFF7F)
            && core_rdata[7] == 1'b0)
        else $error("control read wrong");

    a_soft_reset: assert property (@(posedge sys_clk) disable iff (rst)
        sw_reset |=> st.ctrl == 16'h0000)
        else $error("software reset did not clear control");

    a_gpio_off: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(c.gpio_port_enable) |-> (pin_oe & ~pin_fn) == 5'h00)
        else $error("gpio driven while port disabled");

    a_disable_all: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) && !$past(c.interface_enable) |-> pin_fn == 5'h00 && ifc_reset
            && !vec_oe && !host_sel)
        else $error("host function active while disabled");

    a_addr_mux: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[0] || pin_fn[1] |-> $past(c.muxed_bus_select))
        else $error("address pin used outside multiplexed mode");

    a_req_drain: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[3] && $past(c.request_open_drain) |-> pin_o[3] == 1'b0
            && pin_oe[3] == !($past(tx_req) ~^ $past(c.request_polarity)))
        else $error("open drain request wrong");

    a_req_level: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[3] && !$past(c.request_open_drain) |-> pin_oe[3]
            && pin_o[3] == ($past(tx_req) ~^ $past(c.request_polarity)))
        else $error("request level wrong");

    a_ack_vector: assert property (@(posedge sys_clk) disable iff (rst)
        vec_oe |-> $past(c.ack_pin_enable && c.request_pin_enable
            && !dual_request_mode) && vec_o == $past(vector_reg))
        else $error("vector driven without acknowledge");

    a_single_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(c.dual_strobe_select) |-> !(xfer_rd && xfer_wr))
        else $error("single strobe read and write together");

    a_addr8_pin: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[0] == $past(c.interface_enable && c.muxed_bus_select
            && c.addr8_pin_enable))
        else $error("address line 8 pin function wrong");

    a_addr9_pin: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[1] == $past(c.interface_enable && c.muxed_bus_select
            && c.addr9_pin_enable))
        else $error("address line 9 pin function wrong");

    a_select_pin: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[2] == $past(c.interface_enable && c.select_pin_enable))
        else $error("select pin function wrong");

    a_req_pin: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[3] == $past(c.interface_enable && c.request_pin_enable))
        else $error("request pin function wrong");

    a_ack_pin: assert property (@(posedge sys_clk) disable iff (rst)
        pin_fn[4] == $past(c.interface_enable && c.request_pin_enable
            && (dual_request_mode || c.ack_pin_enable)))
        else $error("acknowledge pin function wrong");

    a_ifc_level: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> ifc_reset == !$past(c.interface_enable))
        else $error("individual reset level wrong");

    a_gpio_input: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(c.gpio_port_enable) |-> gpio_in == 5'h00)
        else $error("gpio input seen while port disabled");

    a_addr_latch: assert property (@(posedge sys_clk) disable iff (rst)
        $past(c.muxed_bus_select) |-> reg_addr == $past(st.alatch))
        else $error("multiplexed address not taken from latch");

    a_strobe_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !host_sel |-> !xfer_rd && !xfer_wr)
        else $error("transfer without select");

    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(core_rd) |-> core_rdata == 16'h0000)
        else $error("read data without read");

    a_mux_select: assert property (@(posedge sys_clk) disable iff (rst)
        $past(c.interface_enable && c.muxed_bus_select) |-> host_sel)
        else $error("multiplexed mode not selected");

endmodule : hpc_port_ctrl

// ---- tb_host_port_pin_config.sv ----
`include "hpc_defines.svh"
module tb_host_port_pin_config;
    timeunit 1ns;
    timeprecision 1ps;
    import hpc_pkg::*;

    logic        sys_clk = 1'b0, rst = 1'b1, sw_reset = 1'b0;
    logic [23:0] core_addr = 24'h000000;
    logic        core_wr = 1'b0, core_rd = 1'b0, dual_request_mode = 1'b0;
    logic        tx_req = 1'b0, rx_req = 1'b0, cyc_rd = 1'b0, cyc_wr = 1'b0, ack_on = 1'b0;
    logic [15:0] core_wdata = 16'h0000, core_rdata;
    logic [7:0]  vector_reg = 8'hA5, vec_o;
    logic [4:0]  pin_direction_reg = 5'h00, pin_value_reg = 5'h15;
    logic [4:0]  pin_i, pin_o, pin_oe, pin_fn, gpio_in;
    logic [2:0]  haddr = 3'h5, reg_addr, host_ad_in, host_addr_in;
    logic        vec_oe, host_sel, xfer_rd, xfer_wr, ifc_reset, host_as_in;
    logic        data_strobe_in, read_strobe_in, write_strobe_in, host_rw_in;
    hpc_ctrl_t   cfg = '0;
    int          failures = 0, comparisons = 0;
    localparam logic [23:0] A = `HPC_CTRL_ADDR;

    hpc_port_ctrl hpc_port_ctrl_inst (.sys_clk, .rst, .sw_reset, .core_addr, .core_wr,
        .core_rd, .core_wdata, .core_rdata, .dual_request_mode, .tx_req, .rx_req,
        .vector_reg, .pin_direction_reg, .pin_value_reg, .pin_i, .host_as_in,
        .data_strobe_in, .read_strobe_in, .write_strobe_in, .host_rw_in, .host_ad_in,
        .host_addr_in, .pin_o, .pin_oe, .vec_o, .vec_oe, .pin_fn, .gpio_in, .reg_addr,
        .host_sel, .xfer_rd, .xfer_wr, .ifc_reset);
    hpc_host_model hpc_host_model_inst (.cfg, .cyc_rd, .cyc_wr, .ack_on, .addr(haddr),
        .pin_o, .pin_oe, .pin_i, .host_as_in, .data_strobe_in, .read_strobe_in,
        .write_strobe_in, .host_rw_in, .host_ad_in, .host_addr_in);

    always #5 sys_clk = ~sys_clk;

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        core_addr = a;
        core_wdata = d;
        core_wr = 1'b1;
        step(1);
        core_wr = 1'b0;
        if (a == A) cfg = d;
        step(5);
    endtask : wr

    task automatic rd(input logic [15:0] exp);
        core_addr = A;
        core_rd = 1'b1;
        step(1);
        core_rd = 1'b0;
        chk(core_rdata, exp);
    endtask : rd

    // Mode bits change only with the interface disabled
    task automatic cfgw(input logic [15:0] d);
        wr(A, 16'(cfg) & 16'hFFBF);
        wr(A, d & 16'hFFBF);
        wr(A, d);
    endtask : cfgw

    task automatic t_reg;
        rd(16'h0000);
        cfgw(16'hFFFF);
        rd(16'hFF7F);
        wr(A + 24'h1, 16'h0000);
        rd(16'hFF7F);
        sw_reset = 1'b1;
        step(1);
        sw_reset = 1'b0;
        cfg = '0;
        step(1);
        rd(16'h0000);
    endtask : t_reg

    task automatic t_fn;
        wr(A, 16'h003E);
        chk(16'(pin_fn), 16'h0000);
        chk(16'(ifc_reset), 16'h0001);
        wr(A, 16'h007E);
        chk(16'(pin_fn), 16'h001C);
        chk(16'(ifc_reset), 16'h0000);
        cfgw(16'h0856);
        chk(16'(pin_fn), 16'h000B);
        cfgw(16'h087E);
        chk(16'(pin_fn), 16'h001F);
    endtask : t_fn

    task automatic t_req;
        dual_request_mode = 1'b1;
        tx_req = 1'b1;
        cfgw(16'h0050);
        chk(16'({pin_fn, pin_oe[4:3], pin_o[4:3]}), 16'h018E);
        dual_request_mode = 1'b0;
        cfgw(16'h4150);
        chk(16'(pin_oe[3]), 16'h0000);
        tx_req = 1'b0;
        step(5);
        chk(16'({pin_oe[3], pin_o[3]}), 16'h0002);
    endtask : t_req

    task automatic t_ack;
        cfgw(16'h8070);
        ack_on = 1'b1;
        step(5);
        chk(16'({vec_oe, vec_o}), 16'h01A5);
        ack_on = 1'b0;
        step(5);
        chk(16'(vec_oe), 16'h0000);
    endtask : t_ack

    task automatic t_strobe;
        cfgw(16'h2048);
        cyc_rd = 1'b1;
        step(5);
        chk(16'({host_sel, xfer_rd, xfer_wr, reg_addr}), 16'h0035);
        cyc_rd = 1'b0;
        cfgw(16'h3248);
        haddr = 3'h2;
        cyc_wr = 1'b1;
        step(5);
        chk(16'({host_sel, xfer_rd, xfer_wr, reg_addr}), 16'h002A);
        cyc_wr = 1'b0;
        cfgw(16'h0C48);
        haddr = 3'h6;
        cyc_rd = 1'b1;
        step(5);
        cyc_rd = 1'b0;
        haddr = 3'h3;
        step(5);
        chk(16'(reg_addr), 16'h0006);
    endtask : t_strobe

    task automatic t_gpio;
        wr(A, 16'h0000);
        pin_direction_reg = 5'h1F;
        step(5);
        chk(16'({pin_oe, gpio_in}), 16'h0000);
        wr(A, 16'h0001);
        chk(16'({pin_oe, pin_o}), 16'h03F5);
        cfgw(16'h0049);
        chk(16'(pin_oe), 16'h001B);
        wr(A, 16'h0001);
        pin_direction_reg = 5'h00;
        step(5);
        chk(16'(gpio_in), 16'h001F);
    endtask : t_gpio

    task automatic final_report;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        step(5);
        rst = 1'b0;
        step(1);
        t_reg();
        t_fn();
        t_req();
        t_ack();
        t_strobe();
        t_gpio();
        final_report();
    end

    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule : tb_host_port_pin_config
